// ### src/mc_scope.sv
// Per-core machine check status banks, scope signalling and APB slave.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Capability count reports banks zero to count-1
// - Valid flag qualifies every other bank field
// - Context-corrupt flag set when processor state corrupted
// - Overflow flag marks lost logging, nothing more
// - Uncorrected flag set only when hardware failed
// - Restart-valid set only when resumption is reliable
// - IP-valid set only when pushed IP relates
// - Exception while in progress enters shutdown
// - Enable grants north bridge checks to one core
// - Corrupt and uncorrected is fatal, raises exception
// - Restartable uncorrected error raises an exception
// - Uncorrected, not restartable: containable, raises exception
// - Deferred error raises exception only on consumption
// - Correctable error only counts, raises no exception
module mc_scope
    import mc_scope_pkg::*;
#(
    parameter int NUM_BANKS = 7
) (
    input  wire logic                         CLOCK,          // core clock
    input  wire logic                         RST_N,          // reset, low
    input  wire logic                         PSEL,           // APB select
    input  wire logic                         PENABLE,        // APB enable
    input  wire logic                         PWRITE,         // APB write
    input  wire logic [mc_scope_pkg::ADDR_W-1:0] PADDR,       // APB address
    input  wire logic [mc_scope_pkg::DATA_W-1:0] PWDATA,      // APB wdata
    output logic      [mc_scope_pkg::DATA_W-1:0] PRDATA,      // APB rdata
    output logic                              PREADY,         // APB ready
    output logic                              PSLVERR,        // APB error
    input  wire logic                         ERR_VALID,      // error report
    input  wire logic [$clog2(NUM_BANKS)-1:0] ERR_BANK,       // its bank
    input  wire logic [mc_scope_pkg::CODE_W-1:0] ERR_CODE,    // error code
    input  wire logic                         ERR_PCC,        // ctx corrupt
    input  wire logic                         ERR_UC,         // uncorrected
    input  wire logic                         ERR_DEFERRED,   // deferred
    input  wire logic                         ERR_POISON,     // poison use
    input  wire logic                         ERR_RESTART_OK, // resumable
    input  wire logic                         ERR_IP_RELATED, // IP related
    input  wire logic                         CONSUME_VALID,  // data used
    input  wire logic [$clog2(NUM_BANKS)-1:0] CONSUME_BANK,   // its bank
    input  wire logic [mc_scope_pkg::CORE_W-1:0] CORE_ID,     // core strap
    output logic                              MCE_PULSE,      // exception
    output logic                              THRESH_PULSE,   // count only
    output logic                              SHUTDOWN,       // shut state
    output logic                              NB_ACCESS_GRANT // NB access
);
    import mc_scope_pkg::*;

    localparam int BANK_W = $clog2(NUM_BANKS);
    localparam int WORD_W = $bits(bank_word_t);

    if (NUM_BANKS < 2 || NUM_BANKS > 32) begin : g_bank_check
        $error("NUM_BANKS must lie between 2 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers.

    function automatic logic bank_hit(input logic [ADDR_W-1:0] a);
        int ai;
        ai = int'(a);
        return (ai >= int'(OFF_BANK0)) &&
               (ai < int'(OFF_BANK0) + 4 * NUM_BANKS) &&
               (a[1:0] == 2'b00);
    endfunction

    function automatic logic [BANK_W-1:0] bank_idx(
        input logic [ADDR_W-1:0] a
    );
        logic [ADDR_W-1:0] rel;
        rel = a - OFF_BANK0;
        return rel[BANK_W+1:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    bus_state_t              bus_q, bus_d;
    logic [DATA_W-1:0]       rdata_q, rdata_d;
    logic                    ready_q, ready_d;
    logic                    slverr_q, slverr_d;

    logic [NUM_BANKS-1:0]    valid_q, valid_d;
    logic [NUM_BANKS-1:0]    ovf_q, ovf_d;
    logic [NUM_BANKS-1:0]    defer_q, defer_d;
    logic                    restart_q, restart_d;
    logic                    ipvalid_q, ipvalid_d;
    logic                    inprog_q, inprog_d;
    logic                    shut_q, shut_d;
    logic                    mce_q, mce_d;
    logic                    thr_q, thr_d;
    scope_t                  scope_q, scope_d;
    logic                    nben_q, nben_d;
    logic [CORE_W-1:0]       master_q, master_d;
    logic                    grant_q, grant_d;
    logic [CORE_W-1:0]       core_s1_q;
    logic [CORE_W-1:0]       core_s2_q;

    logic                    mem_we;
    bank_word_t              mem_wword;
    logic [WORD_W-1:0]       mem_rd;
    bank_word_t              rd_word;
    logic                    wr_commit;
    logic                    log_in_range;
    logic                    use_in_range;
    logic                    log_raise;
    logic                    use_raise;

    scope_if scope_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Classifier and bank memory.

    assign scope_bus.context_corrupt_flag        = ERR_PCC;
    assign scope_bus.uc         = ERR_UC;
    assign scope_bus.restart_ok = ERR_RESTART_OK;
    assign scope_bus.ip_related = ERR_IP_RELATED;
    assign scope_bus.deferred   = ERR_DEFERRED;
    assign scope_bus.poison     = ERR_POISON;

    scope_classify u_classify (
        .s (scope_bus.cls)
    );

    bank_store #(
        .DEPTH (NUM_BANKS),
        .WIDTH (WORD_W)
    ) u_store (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .we      (mem_we),
        .waddr   (ERR_BANK),
        .wdata   (mem_wword),
        .raddr   (bank_idx(PADDR)),
        .rdata_q (mem_rd)
    );

    assign rd_word = bank_word_t'(mem_rd);

    ////////////////////////////////////////////////////////////////////////
    // APB slave: setup, one fetch cycle for the registered memory, done.

    assign wr_commit = PSEL && PENABLE && PWRITE && ready_q;

    always_comb begin
        bus_d    = bus_q;
        rdata_d  = rdata_q;
        ready_d  = 1'b0;
        slverr_d = 1'b0;
        case (bus_q)
            BUS_IDLE: begin
                if (PSEL && !PENABLE) begin
                    bus_d = BUS_FETCH;
                end
            end
            BUS_FETCH: begin
                ready_d  = 1'b1;
                bus_d    = BUS_DONE;
                rdata_d  = RESET_WORD;
                slverr_d = 1'b0;
                if (PADDR == OFF_CAP) begin
                    rdata_d[COUNT_W-1:0] = COUNT_W'(NUM_BANKS);
                end else if (PADDR == OFF_GSTAT) begin
                    rdata_d[GS_RESTART] = restart_q;
                    rdata_d[GS_IPVALID] = ipvalid_q;
                    rdata_d[GS_INPROG]  = inprog_q;
                    rdata_d[GS_SHUT]    = shut_q;
                end else if (PADDR == OFF_CTRL) begin
                    rdata_d[CTRL_NBEN] = nben_q;
                    rdata_d[CTRL_MASTER +: CORE_W] = master_q;
                end else if (PADDR == OFF_SCOPE) begin
                    rdata_d[2:0] = scope_q;
                end else if (bank_hit(PADDR)) begin
                    // Fields of an empty bank read as zero, never stale.
                    if (valid_q[bank_idx(PADDR)]) begin
                        rdata_d[BS_VALID] = 1'b1;
                        rdata_d[BS_OVF]   = ovf_q[bank_idx(PADDR)];
                        rdata_d[BS_UC]    = rd_word.uc;
                        rdata_d[BS_PCC]   = rd_word.context_corrupt_flag;
                        rdata_d[BS_DEFER] = rd_word.deferred;
                        rdata_d[BS_POIS]  = rd_word.poison;
                        rdata_d[CODE_W-1:0] = rd_word.code;
                    end
                end else begin
                    slverr_d = 1'b1;
                end
                if (!PSEL) begin
                    bus_d   = BUS_IDLE;
                    ready_d = 1'b0;
                end
            end
            BUS_DONE: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            bus_q    <= BUS_IDLE;
            rdata_q  <= RESET_WORD;
            ready_q  <= 1'b0;
            slverr_q <= 1'b0;
        end else begin
            bus_q    <= bus_d;
            rdata_q  <= rdata_d;
            ready_q  <= ready_d;
            slverr_q <= slverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error logging, scope signalling and software writes.

    assign log_in_range = ERR_VALID && (int'(ERR_BANK) < NUM_BANKS);
    assign use_in_range = CONSUME_VALID && (int'(CONSUME_BANK) < NUM_BANKS);

    // A bank keeps its first error; a later one only marks overflow.
    assign mem_we = log_in_range && !valid_q[ERR_BANK];

    always_comb begin
        mem_wword.code     = ERR_CODE;
        mem_wword.uc       = ERR_UC;
        mem_wword.context_corrupt_flag      = ERR_PCC;
        mem_wword.deferred = ERR_DEFERRED;
        mem_wword.poison   = ERR_POISON;
    end

    assign log_raise = log_in_range && scope_bus.raise_exc;
    assign use_raise = use_in_range && valid_q[CONSUME_BANK] &&
                       defer_q[CONSUME_BANK];

    always_comb begin
        valid_d   = valid_q;
        ovf_d     = ovf_q;
        defer_d   = defer_q;
        restart_d = restart_q;
        ipvalid_d = ipvalid_q;
        inprog_d  = inprog_q;
        shut_d    = shut_q;
        scope_d   = scope_q;
        nben_d    = nben_q;
        master_d  = master_q;
        mce_d     = 1'b0;
        thr_d     = 1'b0;
        // Software writes come first so a same-cycle event overrides them.
        if (wr_commit && !slverr_q) begin
            if (PADDR == OFF_GSTAT && !PWDATA[GS_INPROG]) begin
                inprog_d = 1'b0;
            end
            if (PADDR == OFF_CTRL) begin
                nben_d   = PWDATA[CTRL_NBEN];
                master_d = PWDATA[CTRL_MASTER +: CORE_W];
            end
            if (bank_hit(PADDR)) begin
                // Writing zero empties the bank for the next error.
                valid_d[bank_idx(PADDR)] = PWDATA[BS_VALID];
                ovf_d[bank_idx(PADDR)]   = PWDATA[BS_OVF];
                defer_d[bank_idx(PADDR)] = PWDATA[BS_DEFER];
            end
        end
        if (log_in_range) begin
            scope_d = scope_bus.scope;
            if (valid_q[ERR_BANK]) begin
                ovf_d[ERR_BANK] = 1'b1;
            end else begin
                valid_d[ERR_BANK] = 1'b1;
                ovf_d[ERR_BANK]   = 1'b0;
                defer_d[ERR_BANK] = ERR_DEFERRED && !ERR_UC;
            end
            thr_d = scope_bus.count_only;
        end
        if (log_raise || use_raise) begin
            if (inprog_q || shut_q) begin
                shut_d = 1'b1;
            end else begin
                mce_d    = 1'b1;
                inprog_d = 1'b1;
                if (log_raise) begin
                    restart_d = ERR_RESTART_OK && !ERR_PCC;
                    ipvalid_d = ERR_IP_RELATED;
                end else begin
                    // A consumed deferred error cannot resume the program.
                    restart_d = 1'b0;
                    ipvalid_d = 1'b1;
                    scope_d   = SC_CONTAIN;
                end
            end
        end
        grant_d = nben_q && (core_s2_q == master_q);
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            valid_q   <= '0;
            ovf_q     <= '0;
            defer_q   <= '0;
            restart_q <= 1'b0;
            ipvalid_q <= 1'b0;
            inprog_q  <= 1'b0;
            shut_q    <= 1'b0;
            mce_q     <= 1'b0;
            thr_q     <= 1'b0;
            scope_q   <= SC_NONE;
            nben_q    <= 1'b0;
            master_q  <= '0;
            grant_q   <= 1'b0;
            core_s1_q <= '0;
            core_s2_q <= '0;
        end else begin
            valid_q   <= valid_d;
            ovf_q     <= ovf_d;
            defer_q   <= defer_d;
            restart_q <= restart_d;
            ipvalid_q <= ipvalid_d;
            inprog_q  <= inprog_d;
            shut_q    <= shut_d;
            mce_q     <= mce_d;
            thr_q     <= thr_d;
            scope_q   <= scope_d;
            nben_q    <= nben_d;
            master_q  <= master_d;
            grant_q   <= grant_d;
            core_s1_q <= CORE_ID;
            core_s2_q <= core_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign PRDATA          = rdata_q;
    assign PREADY          = ready_q;
    assign PSLVERR         = slverr_q;
    assign MCE_PULSE       = mce_q;
    assign THRESH_PULSE    = thr_q;
    assign SHUTDOWN        = shut_q;
    assign NB_ACCESS_GRANT = grant_q;

endmodule
`default_nettype wire

// ### src/mc_scope_pkg.sv
// Constants, field layouts and types shared by the machine check scope block.
`default_nettype none
package mc_scope_pkg;

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int CODE_W  = 16;
    localparam int COUNT_W = 8;
    localparam int CORE_W  = 4;

    // Register byte offsets; bank status words follow each other from BANK0.
    localparam logic [ADDR_W-1:0] OFF_CAP   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_GSTAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SCOPE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_BANK0 = 8'h40;

    // Global status bit positions.
    localparam int GS_RESTART = 0;
    localparam int GS_IPVALID = 1;
    localparam int GS_INPROG  = 2;
    localparam int GS_SHUT    = 3;

    // Control register fields.
    localparam int CTRL_NBEN   = 0;
    localparam int CTRL_MASTER = 8;

    // Bank status bit positions; the error code sits in the low bits.
    localparam int BS_VALID = 31;
    localparam int BS_OVF   = 30;
    localparam int BS_UC    = 29;
    localparam int BS_PCC   = 28;
    localparam int BS_DEFER = 27;
    localparam int BS_POIS  = 26;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        SC_NONE,
        SC_FATAL,
        SC_RESTART,
        SC_CONTAIN,
        SC_DEFER,
        SC_CORRECT
    } scope_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_FETCH,
        BUS_DONE
    } bus_state_t;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic              uc;
        logic              context_corrupt_flag;
        logic              deferred;
        logic              poison;
    } bank_word_t;

endpackage
`default_nettype wire

// ### src/scope_if.sv
// Carrier between the scope block and its classifier.
`timescale 1ns/1ps
`default_nettype none
interface scope_if;
    import mc_scope_pkg::*;
    logic   context_corrupt_flag;
    logic   uc;
    logic   restart_ok;
    logic   ip_related;
    logic   deferred;
    logic   poison;
    scope_t scope;
    logic   raise_exc;
    logic   count_only;

    modport cls (
        input  context_corrupt_flag, uc, restart_ok, ip_related, deferred, poison,
        output scope, raise_exc, count_only
    );
    modport user (
        output context_corrupt_flag, uc, restart_ok, ip_related, deferred, poison,
        input  scope, raise_exc, count_only
    );
endinterface
`default_nettype wire

// ### src/scope_classify.sv
// Error scope classifier: maps the flags of one error onto its scope.
`timescale 1ns/1ps
`default_nettype none
module scope_classify (
    scope_if.cls s  // flags in, scope and signalling out
);
    import mc_scope_pkg::*;

    always_comb begin
        s.scope      = SC_NONE;
        s.raise_exc  = 1'b0;
        s.count_only = 1'b0;
        if (s.context_corrupt_flag && s.uc) begin
            s.scope     = SC_FATAL;
            s.raise_exc = 1'b1;
        end else if (s.context_corrupt_flag) begin
            // Corrupt context without the uncorrected flag is still fatal.
            s.scope     = SC_FATAL;
            s.raise_exc = 1'b1;
        end else if (s.uc && s.restart_ok && s.ip_related) begin
            s.scope     = SC_RESTART;
            s.raise_exc = 1'b1;
        end else if (s.uc) begin
            s.scope     = SC_CONTAIN;
            s.raise_exc = 1'b1;
        end else if (s.deferred && !s.poison) begin
            s.scope     = SC_DEFER;
        end else if (s.poison) begin
            // Consumed poison without an uncorrected flag is contained.
            s.scope     = SC_CONTAIN;
            s.raise_exc = 1'b1;
        end else begin
            s.scope      = SC_CORRECT;
            s.count_only = 1'b1;
        end
    end

endmodule
`default_nettype wire

// ### src/bank_store.sv
// Small memory holding the logged fields of each error bank.
`timescale 1ns/1ps
`default_nettype none
module bank_store #(
    parameter int DEPTH = 7,
    parameter int WIDTH = 20
) (
    input  wire logic                     clk,    // core clock
    input  wire logic                     rst_n,  // async reset, low
    input  wire logic                     we,     // write strobe
    input  wire logic [$clog2(DEPTH)-1:0] waddr,  // write index
    input  wire logic [WIDTH-1:0]         wdata,  // write word
    input  wire logic [$clog2(DEPTH)-1:0] raddr,  // read index
    output logic      [WIDTH-1:0]         rdata_q // registered read word
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_d;

    if (DEPTH < 2) begin : g_depth_check
        $error("bank_store needs at least two words");
    end

    always_comb begin
        rdata_d = mem[raddr];
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

endmodule
`default_nettype wire

// ### testbench/mc_scope_checker.sv
// Port-level assertions for the machine check scope block.
`timescale 1ns/1ps
`default_nettype none
module mc_scope_checker
    import mc_scope_pkg::*;
#(
    parameter int NUM_BANKS = 7
) (
    input wire logic                              CLOCK,          // clock
    input wire logic                              RST_N,          // reset
    input wire logic                              PSEL,           // select
    input wire logic                              PENABLE,        // enable
    input wire logic                              PWRITE,         // write
    input wire logic [mc_scope_pkg::ADDR_W-1:0]   PADDR,          // address
    input wire logic [mc_scope_pkg::DATA_W-1:0]   PRDATA,         // rdata
    input wire logic                              PREADY,         // ready
    input wire logic                              PSLVERR,        // error
    input wire logic                              ERR_VALID,      // report
    input wire logic [$clog2(NUM_BANKS)-1:0]      ERR_BANK,       // bank
    input wire logic                              ERR_PCC,        // corrupt
    input wire logic                              ERR_UC,         // uncorr
    input wire logic                              ERR_DEFERRED,   // deferred
    input wire logic                              ERR_POISON,     // poison
    input wire logic                              CONSUME_VALID,  // consume
    input wire logic                              MCE_PULSE,      // exception
    input wire logic                              THRESH_PULSE,   // count
    input wire logic                              SHUTDOWN,       // shutdown
    input wire logic                              NB_ACCESS_GRANT // grant
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic ev;
    logic quiet;
    logic rd_done;
    assign ev = ERR_VALID && (int'(ERR_BANK) < NUM_BANKS);
    assign quiet = ev && !ERR_PCC && !ERR_UC && !ERR_POISON && !CONSUME_VALID;
    assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    ////////////////////////////////////////////////////////////////////////
    a_fatal_mce: assert property (ev && ERR_PCC && ERR_UC
        |=> MCE_PULSE || SHUTDOWN) else $error("fatal error not raised");
    a_defer_quiet: assert property (quiet && ERR_DEFERRED
        |=> !MCE_PULSE) else $error("deferred error raised exception");
    a_correct_quiet: assert property (quiet && !ERR_DEFERRED
        |=> !MCE_PULSE) else $error("correctable error raised exception");
    a_thresh_cause: assert property (THRESH_PULSE |-> $past(
        ERR_VALID && !ERR_UC && !ERR_PCC && !ERR_DEFERRED && !ERR_POISON))
        else $error("count pulse without correctable error");
    a_mce_cause: assert property (MCE_PULSE
        |-> $past(ERR_VALID || CONSUME_VALID))
        else $error("exception without cause");
    a_mce_nested: assert property (MCE_PULSE |=> !MCE_PULSE)
        else $error("exception delivered while in progress");
    a_shut_sticky: assert property (SHUTDOWN |=> SHUTDOWN)
        else $error("shutdown left");
    a_ready_late: assert property (PSEL && !PENABLE
        |=> !PREADY ##1 PREADY) else $error("ready not in access cycle two");
    a_cap_count: assert property (rd_done && PADDR == OFF_CAP
        |-> PRDATA[7:0] == 8'(NUM_BANKS) && !PSLVERR)
        else $error("bank count wrong");
    a_valid_zero: assert property (rd_done && PADDR >= OFF_BANK0
        && !PSLVERR && !PRDATA[BS_VALID] |-> PRDATA == 32'h0)
        else $error("invalid bank shows fields");
    c_mce: cover property (MCE_PULSE);
    c_thresh: cover property (THRESH_PULSE);
    c_shut: cover property ($rose(SHUTDOWN));
    c_grant: cover property (NB_ACCESS_GRANT);
endmodule

bind mc_scope mc_scope_checker #(.NUM_BANKS(NUM_BANKS)) chk_u (
    .CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
    .PSLVERR, .ERR_VALID, .ERR_BANK, .ERR_PCC, .ERR_UC, .ERR_DEFERRED,
    .ERR_POISON, .CONSUME_VALID, .MCE_PULSE, .THRESH_PULSE, .SHUTDOWN,
    .NB_ACCESS_GRANT
);
`default_nettype wire

// ### testbench/mc_scope_tb_top.sv
// Self-checking bench of the machine check scope block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    $display("wrong value %s exp %h got %h", n, e, s); \
    fail_count++; end end
module mc_scope_tb_top;
    import mc_scope_pkg::*;
    localparam int NB = 7;
    localparam int BW = $clog2(NB);
    logic          CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]    PADDR = 0;
    logic [31:0]   PWDATA = 0, PRDATA, rd;
    logic          PREADY, PSLVERR, MCE_PULSE, THRESH_PULSE, SHUTDOWN;
    logic          NB_ACCESS_GRANT, er, m, t;
    logic          ERR_VALID = 0, ERR_PCC = 0, ERR_UC = 0, ERR_DEFERRED = 0;
    logic          ERR_POISON = 0, ERR_RESTART_OK = 0, ERR_IP_RELATED = 0;
    logic          CONSUME_VALID = 0;
    logic [BW-1:0] ERR_BANK = 0, CONSUME_BANK = 0;
    logic [15:0]   ERR_CODE = 0;
    logic [3:0]    CORE_ID = 4'h3;
    int            fail_count = 0, num_checks = 0, cyc = 0;

    mc_scope #(.NUM_BANKS(NB)) dut_u (.CLOCK, .RST_N, .PSEL, .PENABLE,
        .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ERR_VALID,
        .ERR_BANK, .ERR_CODE, .ERR_PCC, .ERR_UC, .ERR_DEFERRED, .ERR_POISON,
        .ERR_RESTART_OK, .ERR_IP_RELATED, .CONSUME_VALID, .CONSUME_BANK,
        .CORE_ID, .MCE_PULSE, .THRESH_PULSE, .SHUTDOWN, .NB_ACCESS_GRANT);

    always #20 CLOCK = ~CLOCK;
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hung slave would stall every later scenario, so the run is capped.
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // Only the cycle ceiling ends a wait for a slave that never answers.
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mk,
                          input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e & mk, rd & mk)
    endtask

    // Flag order: corrupt, uncorrected, restart, ip, deferred, poison.
    task automatic fire(input int b, input logic [5:0] f, input logic c);
        @(posedge CLOCK);
        ERR_VALID <= !c;
        CONSUME_VALID <= c;
        ERR_BANK <= BW'(b);
        CONSUME_BANK <= BW'(b);
        ERR_CODE <= 16'h5a00 | 16'(b);
        {ERR_PCC, ERR_UC, ERR_RESTART_OK, ERR_IP_RELATED, ERR_DEFERRED,
         ERR_POISON} <= f;
        @(posedge CLOCK);
        ERR_VALID <= 1'b0;
        CONSUME_VALID <= 1'b0;
        #1;
        m = MCE_PULSE;
        t = THRESH_PULSE;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b1, OFF_CAP, 32'h0);
        rd_chk(OFF_CAP, 32'hff, NB, "count");
        rd_chk(OFF_GSTAT, 32'hf, 32'h0, "global");
        for (int i = 0; i < NB; i++) begin
            rd_chk(OFF_BANK0 + 8'(4 * i), '1, 0, "bank");
        end
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 1'b1, er)
        apb(1'b0, 8'h41, 32'h0);
        `CHK("misaligned", 1'b1, er)
    endtask

    task automatic t_grant();
        logic [31:0] cv [3] = '{32'h0301, 32'h0201, 32'h0300};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_CTRL, cv[i]);
            repeat (4) @(posedge CLOCK);
            `CHK("grant", i == 0, NB_ACCESS_GRANT)
        end
    endtask

    task automatic t_scopes();
        logic [5:0] fl [5] = '{6'b111100, 6'b011100, 6'b010001, 6'b000010, 0};
        logic [1:0] gs [3] = '{2'b10, 2'b11, 2'b00};
        logic [7:0] ba;
        for (int i = 0; i < 5; i++) begin
            ba = OFF_BANK0 + 8'(4 * i);
            fire(i, fl[i], 1'b0);
            `CHK("exception", i < 3, m)
            `CHK("count pulse", i == 4, t)
            rd_chk(OFF_SCOPE, 32'h7, i + 1, "scope");
            rd_chk(ba, 32'hfc00ffff, {2'b10, fl[i][4], fl[i][5], fl[i][1],
                   fl[i][0], 10'h0, 16'h5a00 | 16'(i)}, "bank");
            if (i < 3) begin
                rd_chk(OFF_GSTAT, 32'h7, {1'b1, gs[i]}, "global");
                apb(1'b1, OFF_GSTAT, 32'h0);
            end
            apb(1'b1, ba, 32'h0);
            rd_chk(ba, '1, 0, "cleared");
        end
    endtask

    task automatic t_overflow();
        fire(0, 6'b0, 1'b0);
        fire(0, 6'b0, 1'b0);
        rd_chk(OFF_BANK0, 32'hfc00ffff, 32'hc0005a00, "overflow");
        apb(1'b1, OFF_BANK0, 32'h0);
    endtask

    task automatic t_nested();
        fire(5, 6'b001110, 1'b0);
        `CHK("deferred", 1'b0, m)
        fire(5, 6'b0, 1'b1);
        `CHK("consume", 1'b1, m)
        rd_chk(OFF_GSTAT, 32'h7, 32'h6, "global");
        rd_chk(OFF_SCOPE, 32'h7, 32'h3, "scope");
        fire(6, 6'b110000, 1'b0);
        `CHK("nested", 1'b0, m)
        `CHK("shutdown", 1'b1, SHUTDOWN)
        rd_chk(OFF_GSTAT, 32'h8, 32'h8, "global");
    endtask

    initial begin
        repeat (6) @(posedge CLOCK);
        RST_N <= 1'b1;
        t_regs();
        t_grant();
        t_scopes();
        t_overflow();
        t_nested();
        conclude();
    end
endmodule
`default_nettype wire
